/* File: core/tsas_pkg.sv */
// constants, field layouts and shared types of the touch converter serial sequencer
// assumes nothing beyond a SystemVerilog compiler; imported whole by every design file
package tsas_pkg;

   // register map, byte addresses of aligned 32-bit words
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_RESULT = 8'h08;

   // control register fields
   localparam int CTRL_ENABLE_POS = 0;
   localparam logic CTRL_ENABLE_RESET = 1'b1;

   // status register fields
   localparam int ST_BYTE_LSB = 0;
   localparam int ST_BUSY_POS = 8;
   localparam int ST_HOLD_POS = 9;
   localparam int ST_PHASE_LSB = 10;
   localparam int ST_SELECT_POS = 12;

   // result register fields
   localparam int RES_COUNT_LSB = 16;

   // control byte, sent most significant bit first
   localparam int CTRL_BITS = 8;
   localparam int POS_START = 7;
   localparam int POS_CHAN_HI = 6;
   localparam int POS_CHAN_LO = 4;
   localparam int POS_MODE = 3;
   localparam int POS_SERDFR = 2;
   localparam logic [4:0] ACQ_START_COUNT = 5'h05;
   localparam logic [4:0] REF_KNOWN_COUNT = 5'h06;
   localparam logic [4:0] BYTE_DONE_COUNT = 5'h08;

   // channel select codes
   localparam logic [2:0] CH_Y = 3'h1;
   localparam logic [2:0] CH_X = 3'h5;
   localparam logic [2:0] CH_SPARE = 3'h2;
   localparam logic [2:0] CH_PEN = 3'h6;

   // conversion timing, counted in serial clocks after the control byte
   localparam int CODE_W = 12;
   localparam logic [4:0] STEPS_FULL = 5'h0c;
   localparam logic [4:0] STEPS_SHORT = 5'h08;
   localparam logic [4:0] FIRST_OUT_FALL = 5'h02;
   localparam logic [4:0] LAST_OUT_INDEX = 5'h0d;
   localparam logic [4:0] FRAME_FALLS = 5'h10;
   localparam logic [CODE_W-1:0] SAR_FIRST_MASK = 12'h800;

   // panel switches, multiplexer and reference steering
   typedef struct packed {
      logic tlSupply;
      logic brGround;
      logic blSupply;
      logic blGround;
      logic trSupply;
      logic trGround;
      logic ySet;
      logic xSet;
      logic spareSel;
      logic penSel;
      logic negPanel;
      logic refPanel;
   } tsas_switch_t;

   typedef enum logic [1:0] {PH_IDLE, PH_CTRL, PH_CONV} tsas_phase_t;

endpackage

/* File: core/tsas_sar_if.sv */
// bundle between the sequencer and its successive approximation engine
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface tsas_sar_if import tsas_pkg::*;;
   logic start;
   logic step;
   logic cmpHigh;
   logic [CODE_W-1:0] trial;
   logic [CODE_W-1:0] result;

   modport seq (output start, output step, output cmpHigh, input trial, input result);
   modport engine (input start, input step, input cmpHigh, output trial, output result);
endinterface
`default_nettype wire

/* File: core/tsas_sar.sv */
// successive approximation engine: one bit decision per step, most significant first
// assumes cmpHigh is already synchronised and step is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module tsas_sar
   import tsas_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // sequencer side
   tsas_sar_if.engine sar
);

   typedef struct packed {
      logic [CODE_W-1:0] code;
      logic [CODE_W-1:0] mask;
      logic [CODE_W-1:0] trial;
   } tsas_sar_state_t;

   tsas_sar_state_t r;
   tsas_sar_state_t n;

   // keep the tried bit when the held sample is at or above the trial level
   always_comb
   begin
      n = r;
      if (sar.start)
      begin
         n.code = '0;
         n.mask = SAR_FIRST_MASK;
      end
      else if (sar.step)
      begin
         n.code = sar.cmpHigh ? (r.code | r.mask) : r.code;
         n.mask = r.mask >> 1;
      end
      // twelve-bit trial word: one code step is the reference span over 4096
      n.trial = n.code | n.mask;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         r <= '0;
      else
         r <= n;
   end

   assign sar.trial = r.trial;
   assign sar.result = r.code;

endmodule
`default_nettype wire

/* File: core/tsas_sequencer.sv */
// serial control and conversion sequencer of a resistive touch-screen converter
// assumes serial pins and the comparator come from outside the clk domain; apb master on clk
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module tsas_sequencer
   import tsas_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial link
   input wire logic serialClock,
   input wire logic serialIn,
   input wire logic chipSelectN,
   output logic serialOut,
   output logic serialOutEn,
   output logic busy,
   // converter core
   input wire logic cmpHigh,
   output logic [CODE_W-1:0] dacCode,
   output logic sampleHold,
   // panel drivers and multiplexer
   output logic topLeftSupply,
   output logic bottomRightGround,
   output logic bottomLeftSupply,
   output logic bottomLeftGround,
   output logic topRightSupply,
   output logic topRightGround,
   output logic yAxisDriverSet,
   output logic xAxisDriverSet,
   output logic spareInputSel,
   output logic penChannelSel,
   output logic negInputPanel,
   output logic refFromPanel
);

   typedef struct packed {
      // synchronisers, first stage read only by the second
      logic sclkMeta;
      logic sclkSync;
      logic sclkPrev;
      logic sinMeta;
      logic sinSync;
      logic csNMeta;
      logic csNSync;
      logic cmpMeta;
      logic cmpSync;
      // apb answer
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic enable;
      // sequencing
      tsas_phase_t phase;
      logic [4:0] bitCnt;
      logic [7:0] shiftIn;
      logic [7:0] ctrlByte;
      logic [4:0] convCnt;
      logic [4:0] steps;
      logic [CODE_W-1:0] result;
      logic [15:0] convTotal;
      // pins
      logic serialOut;
      logic serialOutEn;
      logic busy;
      logic hold;
      tsas_switch_t sw;
   } tsas_state_t;

   tsas_state_t r;
   tsas_state_t n;

   tsas_sar_if sarBus();

   logic rise;
   logic fall;
   logic linkOn;
   logic sarStart;
   logic sarStep;
   logic [7:0] shiftNext;
   logic [4:0] cntNext;
   logic [7:0] aligned;
   logic [4:0] outIndex;

   // panel switch, multiplexer and reference steering for one channel code
   function automatic tsas_switch_t decodeSwitches(input logic [2:0] chan, input logic ratio);
      tsas_switch_t s;
      s = '0;
      if (chan == CH_Y || chan == CH_X)
      begin
         s.tlSupply = 1'b1;
         s.brGround = 1'b1;
         if (chan == CH_Y)
         begin
            s.ySet = 1'b1;
            s.blGround = 1'b1;
            s.trSupply = 1'b1;
         end
         else
         begin
            s.xSet = 1'b1;
            s.blSupply = 1'b1;
            s.trGround = 1'b1;
         end
         // ratiometric: references and negative input follow the panel ends
         s.negPanel = ratio;
         s.refPanel = ratio;
      end
      else if (chan == CH_SPARE)
         s.spareSel = 1'b1;
      else if (chan == CH_PEN)
         s.penSel = 1'b1;
      return s;
   endfunction

   // true for the three word addresses that exist
   function automatic logic isMapped(input logic [7:0] addr);
      return addr == REG_CTRL || addr == REG_STATUS || addr == REG_RESULT;
   endfunction

   // read word of a register; unmapped addresses read as zero
   function automatic logic [31:0] readWord(input logic [7:0] addr, input tsas_state_t s);
      logic [31:0] w;
      w = '0;
      if (addr == REG_CTRL)
         w[CTRL_ENABLE_POS] = s.enable;
      else if (addr == REG_STATUS)
      begin
         w[ST_BYTE_LSB +: 8] = s.ctrlByte;
         w[ST_BUSY_POS] = s.busy;
         w[ST_HOLD_POS] = s.hold;
         w[ST_PHASE_LSB +: 2] = s.phase;
         w[ST_SELECT_POS] = ~s.csNSync;
      end
      else if (addr == REG_RESULT)
      begin
         w[CODE_W-1:0] = s.result;
         w[RES_COUNT_LSB +: 16] = s.convTotal;
      end
      return w;
   endfunction

   // next-state logic for the whole block
   always_comb
   begin
      n = r;
      sarStart = 1'b0;
      sarStep = 1'b0;
      shiftNext = {r.shiftIn[6:0], r.sinSync};
      cntNext = r.bitCnt + 5'h01;
      aligned = 8'(shiftNext << (5'(CTRL_BITS) - cntNext));
      outIndex = LAST_OUT_INDEX - r.convCnt;

      // two-stage synchronisers on every pin that crosses into clk
      n.sclkMeta = serialClock;
      n.sclkSync = r.sclkMeta;
      n.sclkPrev = r.sclkSync;
      n.sinMeta = serialIn;
      n.sinSync = r.sinMeta;
      n.csNMeta = chipSelectN;
      n.csNSync = r.csNMeta;
      n.cmpMeta = cmpHigh;
      n.cmpSync = r.cmpMeta;
      rise = r.sclkSync & ~r.sclkPrev;
      fall = ~r.sclkSync & r.sclkPrev;
      linkOn = ~r.csNSync & r.enable;

      // zero-wait apb slave: answer stands in the access cycle only
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      if (psel && !penable)
      begin
         n.pready = 1'b1;
         n.prdata = readWord(paddr, r);
         n.pslverr = ~isMapped(paddr);
      end
      if (psel && penable && r.pready && pwrite && paddr == REG_CTRL)
         n.enable = pwdata[CTRL_ENABLE_POS];

      // output is driven only while selected and enabled
      n.serialOutEn = linkOn;

      if (!linkOn)
      begin
         // deselect aborts any frame; the next one starts from a fresh start bit
         n.phase = PH_IDLE;
         n.bitCnt = '0;
         n.convCnt = '0;
         n.serialOut = 1'b0;
         n.busy = 1'b0;
         n.hold = 1'b0;
         n.sw = '0;
      end
      else
      begin
         unique case (r.phase)
            PH_IDLE:
            begin
               // input is ignored until a high start bit arrives
               if (rise && r.sinSync)
               begin
                  n.phase = PH_CTRL;
                  n.bitCnt = 5'h01;
                  n.shiftIn = 8'h01;
               end
            end
            PH_CTRL:
            begin
               if (rise)
               begin
                  // byte taken most significant bit first on rising edges
                  n.shiftIn = shiftNext;
                  n.bitCnt = cntNext;
                  // channel known: acquire; reference mode joins one clock later
                  if (cntNext >= ACQ_START_COUNT)
                     n.sw = decodeSwitches(aligned[POS_CHAN_HI:POS_CHAN_LO],
                                           cntNext >= REF_KNOWN_COUNT && !aligned[POS_SERDFR]);
                  if (cntNext == BYTE_DONE_COUNT)
                  begin
                     n.ctrlByte = shiftNext;
                     n.phase = PH_CONV;
                     n.convCnt = '0;
                     // hold captures the input difference as the byte completes
                     n.hold = 1'b1;
                     n.busy = 1'b1;
                     sarStart = 1'b1;
                     // mode bit picks the number of decisions
                     n.steps = shiftNext[POS_MODE] ? STEPS_SHORT : STEPS_FULL;
                     // single-ended frees the panel; ratiometric keeps it live
                     if (shiftNext[POS_SERDFR])
                        n.sw = '0;
                     else
                        n.sw = r.sw;
                  end
               end
            end
            PH_CONV:
            begin
               // one bit decision on each rising edge of the conversion clocks
               if (rise && r.convCnt != 5'h00 && r.convCnt <= r.steps)
                  sarStep = 1'b1;
               if (fall)
               begin
                  n.convCnt = r.convCnt + 5'h01;
                  n.busy = 1'b0;
                  // result leaves msb first, one bit per falling edge
                  if (n.convCnt >= FIRST_OUT_FALL && n.convCnt <= r.steps + 5'h01)
                     n.serialOut = sarBus.result[outIndex[3:0] - 4'h1];
                  else
                     n.serialOut = 1'b0;
                  // all decisions made: keep the code and release the panel
                  if (n.convCnt == r.steps + 5'h01)
                  begin
                     n.result = sarBus.result;
                     n.convTotal = r.convTotal + 16'h0001;
                     n.hold = 1'b0;
                     n.sw = '0;
                  end
                  // padding clocks end the frame without further action
                  if (n.convCnt == FRAME_FALLS)
                  begin
                     n.phase = PH_IDLE;
                     n.bitCnt = '0;
                     n.serialOut = 1'b0;
                  end
               end
            end
         endcase
      end
   end

   // single register stage for all state; sync reset to constants only
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         r <= '0;
         r.enable <= CTRL_ENABLE_RESET;
         r.csNMeta <= 1'b1;
         r.csNSync <= 1'b1;
      end
      else
         r <= n;
   end

   // engine hookup; comparator is read only after synchronising
   assign sarBus.start = sarStart;
   assign sarBus.step = sarStep;
   assign sarBus.cmpHigh = r.cmpSync;

   tsas_sar u_sar (
      .clk(clk),
      .reset(reset),
      .sar(sarBus)
   );

   // outputs straight from flip-flops
   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign serialOut = r.serialOut;
   assign serialOutEn = r.serialOutEn;
   assign busy = r.busy;
   assign dacCode = sarBus.trial;
   assign sampleHold = r.hold;
   assign topLeftSupply = r.sw.tlSupply;
   assign bottomRightGround = r.sw.brGround;
   assign bottomLeftSupply = r.sw.blSupply;
   assign bottomLeftGround = r.sw.blGround;
   assign topRightSupply = r.sw.trSupply;
   assign topRightGround = r.sw.trGround;
   assign yAxisDriverSet = r.sw.ySet;
   assign xAxisDriverSet = r.sw.xSet;
   assign spareInputSel = r.sw.spareSel;
   assign penChannelSel = r.sw.penSel;
   assign negInputPanel = r.sw.negPanel;
   assign refFromPanel = r.sw.refPanel;

endmodule
`default_nettype wire

/* File: bench/tsas_sequencer_checker.sv */
// pin-level assertions for the touch converter serial sequencer
// assumes one clk domain; the raw serial clock is sampled here once on clk, without the design's two-stage synchroniser
`timescale 1ns/1ps
`default_nettype none
module tsas_sequencer_checker
   import tsas_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // apb handshake
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   // serial link
   input wire logic serialClock,
   input wire logic chipSelectN,
   input wire logic serialOut,
   input wire logic serialOutEn,
   input wire logic busy,
   // converter and panel
   input wire logic [CODE_W-1:0] dacCode,
   input wire logic sampleHold,
   input wire logic topLeftSupply,
   input wire logic bottomRightGround,
   input wire logic bottomLeftSupply,
   input wire logic bottomLeftGround,
   input wire logic topRightSupply,
   input wire logic topRightGround,
   input wire logic yAxisDriverSet,
   input wire logic xAxisDriverSet,
   input wire logic negInputPanel,
   input wire logic refFromPanel
);
   typedef struct packed {
      logic sck;
      logic [7:0] fallAge;
      logic [7:0] riseAge;
      logic [7:0] holdLen;
   } tsas_chk_t;
   tsas_chk_t chkReg;
   tsas_chk_t chkNext;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   // ages since serial edges and length of hold; saturate so a long idle never wraps
   always_comb
   begin
      chkNext = chkReg;
      chkNext.sck = serialClock;
      if (chkReg.fallAge != 8'hff) chkNext.fallAge = chkReg.fallAge + 8'h01;
      if (chkReg.riseAge != 8'hff) chkNext.riseAge = chkReg.riseAge + 8'h01;
      if (chkReg.sck && !serialClock) chkNext.fallAge = 8'h00;
      if (!chkReg.sck && serialClock) chkNext.riseAge = 8'h00;
      chkNext.holdLen = 8'h00;
      if (sampleHold) chkNext.holdLen = (chkReg.holdLen == 8'hff) ? 8'hff : chkReg.holdLen + 8'h01;
   end

   always_ff @(posedge clk)
   begin
      if (reset) chkReg <= '0;
      else chkReg <= chkNext;
   end

   // byte complete, and end of the conversion inside a live frame
   sequence byteDone;
      $rose(sampleHold) ##0 busy;
   endsequence
   sequence convEnd;
      $fell(sampleHold) ##0 !chipSelectN;
   endsequence

   a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("apb answer is not one cycle after setup");
   a_hold_start: assert property (byteDone |-> chkReg.riseAge < 8'h0c)
      else $error("hold did not start at a serial rising edge");
   a_busy_short: assert property ($rose(busy) |-> ##[1:16] !busy)
      else $error("busy outlasted the next serial fall");
   a_busy_at_hold: assert property ($rose(sampleHold) |-> busy)
      else $error("busy not raised as hold starts");
   a_hold_length: assert property (convEnd |-> chkReg.holdLen >= 8'h78 && chkReg.holdLen <= 8'hd2)
      else $error("hold length wrong for the conversion");
   a_dac_frozen: assert property ($changed(dacCode) |-> sampleHold || $past(sampleHold))
      else $error("trial code moved outside hold");
   a_out_on_fall: assert property ($changed(serialOut) && !chipSelectN |-> chkReg.fallAge < 8'h0c)
      else $error("serial output moved away from a falling edge");
   a_idle_quiet: assert property (chipSelectN [*6] |-> !serialOut && !serialOutEn)
      else $error("serial output not low while deselected");
   a_panel_ends: assert property (yAxisDriverSet || xAxisDriverSet |-> topLeftSupply && bottomRightGround)
      else $error("panel corner drivers wrong");
   a_y_drive: assert property (yAxisDriverSet |-> bottomLeftGround && topRightSupply && !bottomLeftSupply && !topRightGround)
      else $error("y axis drive wrong");
   a_x_drive: assert property (xAxisDriverSet |-> bottomLeftSupply && topRightGround && !bottomLeftGround && !topRightSupply)
      else $error("x axis drive wrong");
   a_ratio_refs: assert property (refFromPanel |-> negInputPanel && (yAxisDriverSet || xAxisDriverSet))
      else $error("panel references without an active axis");
endmodule

bind tsas_sequencer tsas_sequencer_checker chk (.*);
`default_nettype wire

/* File: bench/tsas_host.sv */
// serial host model: 24-clock frames, control byte first, result taken after each fall
// assumes the device answers within half a link period; the link clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
module tsas_host (
   // link to the converter
   output logic serialClock,
   output logic serialIn,
   output logic chipSelectN,
   input wire logic serialOut,
   // link rising edges counted from the start bit
   output logic [4:0] riseCnt
);
   // idle: deselected, clock still
   initial
   begin
      serialClock = 1'b0;
      serialIn = 1'b0;
      chipSelectN = 1'b1;
      riseCnt = 5'h00;
   end

   // lead zero clocks before the start bit; 16 captures follow the byte
   task automatic frame(input logic [7:0] ctrl, input int lead, output logic [15:0] rx);
      rx = 16'h0;
      // step 1.25 ns off the clk grid so no link edge ever meets a clk edge
      #1.25;
      chipSelectN = 1'b0;
      #150;
      for (int i = 0; i < lead + 24; i++)
      begin
         serialIn = (i >= lead && i < lead + 8) ? ctrl[7 - (i - lead)] : 1'b0;
         #62.5;
         if (i >= lead + 8) rx = {rx[14:0], serialOut};
         serialClock = 1'b1;
         if (i >= lead) riseCnt = 5'(i - lead + 1);
         #62.5;
         serialClock = 1'b0;
      end
      #62.5;
      serialIn = ~serialIn; // released line shows the inverse so a stale read cannot pass
      riseCnt = 5'h00;
      chipSelectN = 1'b1;
      #300;
   endtask
endmodule
`default_nettype wire

/* File: bench/touch_adc_serial_sequencer_tb.sv */
// self-checking bench: apb register tasks and host frames over all channels and modes
// assumes the checker is bound in and the host model drives the link
`timescale 1ns/1ps
`default_nettype none
module touch_adc_serial_sequencer_tb
   import tsas_pkg::*;
;
   localparam logic [2:0] CHANS [4] = '{CH_Y, CH_X, CH_SPARE, CH_PEN};
   localparam logic [11:0] TGTS [8] = '{12'hfff, 12'h000, 12'h5a3, 12'h801, 12'h7ff, 12'hc3c, 12'h001, 12'habe};
   logic clk, reset, psel, penable, pwrite, pready, pslverr, cmpHigh;
   logic serialClock, serialIn, chipSelectN, serialOut, serialOutEn, busy, sampleHold;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [CODE_W-1:0] dacCode, target;
   logic [4:0] riseCnt;
   tsas_switch_t sw;
   int errorCnt, numChecks;

   tsas_sequencer dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serialClock(serialClock), .serialIn(serialIn), .chipSelectN(chipSelectN), .serialOut(serialOut),
      .serialOutEn(serialOutEn), .busy(busy), .cmpHigh(cmpHigh), .dacCode(dacCode), .sampleHold(sampleHold),
      .topLeftSupply(sw.tlSupply), .bottomRightGround(sw.brGround), .bottomLeftSupply(sw.blSupply),
      .bottomLeftGround(sw.blGround), .topRightSupply(sw.trSupply), .topRightGround(sw.trGround),
      .yAxisDriverSet(sw.ySet), .xAxisDriverSet(sw.xSet), .spareInputSel(sw.spareSel),
      .penChannelSel(sw.penSel), .negInputPanel(sw.negPanel), .refFromPanel(sw.refPanel));
   tsas_host host (.serialClock(serialClock), .serialIn(serialIn), .chipSelectN(chipSelectN),
      .serialOut(serialOut), .riseCnt(riseCnt));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // comparator stand-in: the held sample equals target
   always @(posedge clk) cmpHigh <= (target >= dacCode);

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
      numChecks++;
      if (seen !== want)
      begin
         errorCnt++;
         $display("Error %s expected %h seen %h", what, want, seen);
      end
   endtask

   task automatic printVerdict();
      $display("checks %0d mismatches %0d", numChecks, errorCnt);
      if (errorCnt == 0 && numChecks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 50) check("apb wait", 32'h0, 32'h1);
      if (n >= 50) printVerdict();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] want, input logic wantErr);
      logic [31:0] d;
      logic e;
      apb(1'b0, a, 32'h0, d, e);
      check(what, d, want);
      check({what, " err"}, {31'h0, e}, {31'h0, wantErr});
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      logic e;
      apb(1'b1, a, d, x, e);
   endtask

   // bounded wait for the host's rising-edge count
   task automatic waitCnt(input logic [4:0] n);
      int k;
      k = 0;
      while (riseCnt !== n && k < 4000)
      begin
         @(posedge clk);
         k++;
      end
      if (k >= 4000) check("frame wait", 32'h0, 32'h1);
      if (k >= 4000) printVerdict();
   endtask

   // panel drive for a channel; mux selects are only looked at during acquisition
   function automatic tsas_switch_t expSw(input logic [2:0] ch, input logic ser, input logic en);
      tsas_switch_t s;
      logic x;
      s = '0;
      x = (ch == CH_X);
      if (en && (ch == CH_Y || x)) s = {2'b11, x, !x, !x, x, !x, x, 2'b00, !ser, !ser};
      s.spareSel = en && ch == CH_SPARE;
      s.penSel = en && ch == CH_PEN;
      return s;
   endfunction

   // one frame, switches checked at rising 7 (acquisition) and 11 (conversion)
   task automatic conv(input logic [7:0] ctrl, input int lead, input logic en, output logic [15:0] rx);
      tsas_switch_t acq;
      acq = expSw(ctrl[6:4], ctrl[2], en);
      fork
         host.frame(ctrl, lead, rx);
         begin
            waitCnt(5'h07);
            check("acq switches", {20'h0, sw}, {20'h0, acq});
            check("out enable", {31'h0, serialOutEn}, {31'h0, en});
            waitCnt(5'h0b);
            check("conv switches", {20'h0, sw & 12'hff0}, {20'h0, ctrl[2] ? 12'h0 : acq & 12'hff0});
         end
      join
      check("idle switches", {20'h0, sw & 12'hff0}, 32'h0);
   endtask

   initial
   begin
      logic [15:0] rx;
      logic [7:0] ctrl;
      logic [11:0] want;
      errorCnt = 0;
      numChecks = 0;
      reset = 1'b1;
      {psel, penable, pwrite, paddr, pwdata, target} = '0;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rdChk("ctrl reset", REG_CTRL, 32'h1, 1'b0);
      rdChk("status reset", REG_STATUS, 32'h0, 1'b0);
      rdChk("result reset", REG_RESULT, 32'h0, 1'b0);
      rdChk("unmapped", 8'h0c, 32'h0, 1'b1);
      $display("test registers done");
      for (int i = 0; i < 8; i++)
      begin
         ctrl = {1'b1, CHANS[i % 4], i == 2 || i == 5, i < 4, 2'b11};
         target <= TGTS[i];
         conv(ctrl, i % 3, 1'b1, rx);
         want = ctrl[3] ? {TGTS[i][11:4], 4'h0} : TGTS[i];
         check("serial result", {16'h0, rx}, {16'h0, 1'b0, want, 3'b000});
         rdChk("result reg", REG_RESULT, {16'(i + 1), 4'h0, want}, 1'b0);
         rdChk("status reg", REG_STATUS, {24'h0, ctrl}, 1'b0);
         $display("test frame %0d done", i);
      end
      wr(REG_STATUS, 32'hffffffff);
      rdChk("status ro", REG_STATUS, {24'h0, ctrl}, 1'b0);
      wr(REG_CTRL, 32'h0);
      rdChk("ctrl off", REG_CTRL, 32'h0, 1'b0);
      conv(8'hd3, 0, 1'b0, rx);
      check("disabled result", {16'h0, rx}, 32'h0);
      rdChk("count kept", REG_RESULT, {16'h8, 4'h0, want}, 1'b0);
      wr(REG_CTRL, 32'h1);
      $display("test enable done");
      printVerdict();
   end
endmodule
`default_nettype wire
